// ---- hw/ppfs_pkg.sv ----
// ppfs_pkg: constants and pin function codes for the port pin function select block
// assumes: one clock domain, synchronous active-high reset, no register bus
package ppfs_pkg;
    // serial channel 2 mode field values
    localparam logic [2:0] SER_MODE_PORT    = 3'h0;
    localparam logic [2:0] SER_MODE_CLK_OUT = 3'h1;
    // reset values of registered outputs
    localparam logic       RST_PIN_LOW      = 1'h0;
    localparam logic [2:0] RST_FUNC         = 3'h0;

    // function reported per pin
    typedef enum logic [2:0] {
        PPFS_FN_IN,
        PPFS_FN_OUT,
        PPFS_FN_PERIPH_OUT,
        PPFS_FN_PERIPH_IN,
        PPFS_FN_OSC
    } ppfs_func_t;
endpackage : ppfs_pkg

// ---- hw/ppfs_mux.sv ----
// ppfs_mux: pin function multiplexer for port 3 bit 7, port 4 bits 3-5, port 6 bits 0 and 3-5
// assumes: pins arrive as input/output/output-enable triples; peripheral data and control bits
// come from logic on mclk; pin inputs pass two flip-flops before use.
// What this block does
// - p3.7 is general in/out by direction when timer A and F outputs are off
// - p3.7 drives timer A output, else timer F ch11 output when A disabled
// - sub-clock select 1, stop 0, fb-disable 0: buffer on, feedback resistor on
// - sub-clock select 1, stop 0, fb-disable 1: buffer on, resistor off
// - sub-clock select 1, stop 1: buffer off, resistor follows fb-disable
// - sub-clock external mode: p4.3 takes clock input, resistor follows fb-disable
// - in external mode p4.4 outputs inverse of sub-clock input
// - sub-clock select 0: pins are ports, buffer and resistor off
// - p4.3 pull-up active in input mode when its pull-up bit is 1
// - p4.5 feeds external interrupt 0 when enabled and direction is input
// - p4.5 pull-up active in input mode when its pull-up bit is 1
// - p6.0 drives timer E output when both selects 0 and enable 1
// - p6.0 and p6.3 pull-ups active in input mode via shared bit
// - p6.3 is general port at mode 000, serial transmit otherwise
// - serial transmit on p6.3 becomes open-drain when open-drain select is 1
// - p6.4 general port; serial receive taken from pin when direction 0
// - p6.4 and p6.5 pull-ups active in any input mode via shared bit
// - p6.5 drives timer E output when alternate select and enable are 1
// - p6.5 with alternate select 0 outputs serial clock at mode 001 and clock-direction 0, inputs it at clock-direction 1 and direction 0
module ppfs_mux (
    input  wire logic                mclk,
    input  wire logic                srst,
    // direction bits
    input  wire logic                port3_bit7_direction,
    input  wire logic                port4_bit3_direction,
    input  wire logic                port4_bit4_direction,
    input  wire logic                port4_bit5_direction,
    input  wire logic                port6_bit0_direction,
    input  wire logic                port6_bit3_direction,
    input  wire logic                port6_bit4_direction,
    input  wire logic                port6_bit5_direction,
    // port output data latches
    input  wire logic [6:0]          port_out_data,
    // peripheral selection and enables
    input  wire logic                timer_a_out_pin_select,
    input  wire logic                timer_a_output_enable,
    input  wire logic                timer_f_out_pin_select,
    input  wire logic                timer_f_out4_enable,
    input  wire logic                timer_e_pin_select,
    input  wire logic                timer_e_alt_pin_select,
    input  wire logic                timer_e_output_enable,
    input  wire logic                subclock_pin_select,
    input  wire logic                subclock_stop,
    input  wire logic                feedback_resistor_disable,
    input  wire logic                ext_irq0_enable,
    input  wire logic                serial_mode_bit2,
    input  wire logic                serial_mode_bit1,
    input  wire logic                serial_mode_bit0,
    input  wire logic                serial_clock_direction,
    input  wire logic                open_drain_select,
    input  wire logic                pullup_p4_low,
    input  wire logic                pullup_p4_high,
    input  wire logic                pullup_p6_low,
    input  wire logic                pullup_p6_high,
    // peripheral signals
    input  wire logic                timer_a_output,
    input  wire logic                timer_f_ch11_output,
    input  wire logic                timer_e_output,
    input  wire logic                serial2_transmit,
    input  wire logic                serial2_clock_out,
    // pins, order: p3.7 p4.3 p4.4 p4.5 p6.0 p6.3 p6.4 p6.5 (bit 0..7)
    input  wire logic [7:0]          pin_in,
    output logic      [7:0]          pin_out,
    output logic      [7:0]          pin_oe,
    output logic      [7:0]          pin_pullup,
    // values seen by peripherals and port read
    output logic      [7:0]          pin_level,
    output logic                     ext_irq0_input,
    output logic                     serial2_receive,
    output logic                     serial2_clock_in,
    output logic                     subclock_in,
    // oscillator circuit controls, then the function reported per pin
    output logic                     osc_buffer_on,
    output logic                     feedback_resistor_on,
    output ppfs_pkg::ppfs_func_t     pin_func [8]
);
    import ppfs_pkg::*;

    // how the pins are built:
    // every control and peripheral bit comes from logic on mclk, so it is read directly
    // every pin level comes from the board, so it passes two flip-flops before any use
    // all drive, enable and pull-up outputs are registered: one mclk after a control change
    // levels handed to peripherals are three mclk behind the pin (two sync stages, one output stage)
    //
    // pin index map used throughout this file:
    //   0: port 3 bit 7 (timer A / timer F channel 11 output)
    //   1: port 4 bit 3 (sub-clock input pin)
    //   2: port 4 bit 4 (sub-clock output pin)
    //   3: port 4 bit 5 (external interrupt 0)
    //   4: port 6 bit 0 (timer E output)
    //   5: port 6 bit 3 (serial 2 transmit)
    //   6: port 6 bit 4 (serial 2 receive)
    //   7: port 6 bit 5 (serial 2 clock / timer E alternate output)
    //
    // hazards and limits a user must know:
    // a timer enable set without its pin select leaves port 3 bit 7 undriven as an input;
    // software must not rely on the direction bit in that state
    // port 6 bit 5 has no output latch of its own and shares the port 6 bit 4 latch bit
    // open-drain transmit never drives high; the line needs a board pull-up to read as one
    // the sub-clock pins carry no pull-up while the oscillator owns them, so a floating
    // crystal pin is the board's concern
    // pull-ups are only ever enabled while the module does not drive the pin, so a pull-up
    // never fights the output stage

    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] out_d;
    logic [7:0] oe_d;
    logic [7:0] pu_d;
    logic       osc_mode;
    logic       ext_clk_mode;
    logic [2:0] ser_mode;
    logic       tx_on;
    logic       clk_out_on;
    logic       clk_in_on;
    logic       te_alt_on;
    logic       ta_on;
    logic       tf_on;
    logic       te_on;
    ppfs_func_t func_d [8];

    assign ser_mode     = {serial_mode_bit2, serial_mode_bit1, serial_mode_bit0};
    assign osc_mode     = subclock_pin_select;
    assign ext_clk_mode = subclock_pin_select && !subclock_stop;
    assign ta_on        = timer_a_out_pin_select && timer_a_output_enable;
    assign tf_on        = timer_f_out_pin_select && timer_f_out4_enable && !timer_a_output_enable;
    assign te_on        = !timer_e_pin_select && !timer_e_alt_pin_select && timer_e_output_enable;
    assign te_alt_on    = timer_e_alt_pin_select && timer_e_output_enable;
    assign tx_on        = (ser_mode != SER_MODE_PORT);
    assign clk_out_on   = !timer_e_alt_pin_select && !serial_clock_direction
                          && (ser_mode == SER_MODE_CLK_OUT);
    assign clk_in_on    = !timer_e_alt_pin_select && serial_clock_direction
                          && !port6_bit5_direction;

    // two-stage synchroniser on every pin input
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // per-pin drive, enable, pull-up and function selection
    // defaults leave every pin an undriven input with no pull-up, so any pin that
    // no branch claims stays harmless; each pin section below only overrides
    // the fields that its selected function needs
    always_comb begin
        out_d   = 8'h00;
        oe_d    = 8'h00;
        pu_d    = 8'h00;
        for (int i = 0; i < 8; i++) begin
            func_d[i] = PPFS_FN_IN;
        end
        // port 3 bit 7
        if (ta_on) begin
            out_d[0] = timer_a_output;
            oe_d[0]  = 1'b1;
            func_d[0] = PPFS_FN_PERIPH_OUT;
        end else if (tf_on) begin
            out_d[0] = timer_f_ch11_output;
            oe_d[0]  = 1'b1;
            func_d[0] = PPFS_FN_PERIPH_OUT;
        end else if (!timer_a_output_enable && !timer_f_out4_enable) begin
            out_d[0] = port_out_data[0];
            oe_d[0]  = port3_bit7_direction;
            func_d[0] = port3_bit7_direction ? PPFS_FN_OUT : PPFS_FN_IN;
        end
        // port 4 bits 3 and 4
        if (osc_mode) begin
            func_d[1] = PPFS_FN_OSC;
            func_d[2] = PPFS_FN_OSC;
            if (ext_clk_mode) begin
                out_d[2] = !sync2_q[1];
                oe_d[2]  = 1'b1;
            end
        end else begin
            out_d[1]  = port_out_data[1];
            oe_d[1]   = port4_bit3_direction;
            func_d[1] = port4_bit3_direction ? PPFS_FN_OUT : PPFS_FN_IN;
            pu_d[1]   = !port4_bit3_direction && pullup_p4_low;
            out_d[2]  = port_out_data[2];
            oe_d[2]   = port4_bit4_direction;
            func_d[2] = port4_bit4_direction ? PPFS_FN_OUT : PPFS_FN_IN;
        end
        // port 4 bit 5
        out_d[3]  = port_out_data[3];
        oe_d[3]   = port4_bit5_direction;
        pu_d[3]   = !port4_bit5_direction && pullup_p4_high;
        if (port4_bit5_direction) begin
            func_d[3] = PPFS_FN_OUT;
        end else if (ext_irq0_enable) begin
            func_d[3] = PPFS_FN_PERIPH_IN;
        end
        // port 6 bit 0
        if (te_on) begin
            out_d[4]  = timer_e_output;
            oe_d[4]   = 1'b1;
            func_d[4] = PPFS_FN_PERIPH_OUT;
        end else begin
            out_d[4]  = port_out_data[4];
            oe_d[4]   = port6_bit0_direction;
            func_d[4] = port6_bit0_direction ? PPFS_FN_OUT : PPFS_FN_IN;
            pu_d[4]   = !port6_bit0_direction && pullup_p6_low;
        end
        // port 6 bit 3
        if (tx_on) begin
            out_d[5]  = open_drain_select ? 1'b0 : serial2_transmit;
            oe_d[5]   = open_drain_select ? !serial2_transmit : 1'b1;
            func_d[5] = PPFS_FN_PERIPH_OUT;
        end else begin
            out_d[5]  = port_out_data[5];
            oe_d[5]   = port6_bit3_direction;
            func_d[5] = port6_bit3_direction ? PPFS_FN_OUT : PPFS_FN_IN;
            pu_d[5]   = !port6_bit3_direction && pullup_p6_low;
        end
        // port 6 bit 4
        out_d[6]  = port_out_data[6];
        oe_d[6]   = port6_bit4_direction;
        func_d[6] = port6_bit4_direction ? PPFS_FN_OUT : PPFS_FN_PERIPH_IN;
        pu_d[6]   = !port6_bit4_direction && pullup_p6_high;
        // port 6 bit 5
        // priority: timer E alternate output, then serial clock out, then serial
        // clock in, then plain port; the timer wins so a stray serial setting
        // cannot take the pin away from a running timer
        if (te_alt_on) begin
            out_d[7]  = timer_e_output;
            oe_d[7]   = 1'b1;
            func_d[7] = PPFS_FN_PERIPH_OUT;
        end else if (clk_out_on) begin
            out_d[7]  = serial2_clock_out;
            oe_d[7]   = 1'b1;
            func_d[7] = PPFS_FN_PERIPH_OUT;
        end else if (clk_in_on) begin
            func_d[7] = PPFS_FN_PERIPH_IN;
            pu_d[7]   = pullup_p6_high;
        end else begin
            out_d[7]  = port_out_data[6];
            oe_d[7]   = port6_bit5_direction;
            func_d[7] = port6_bit5_direction ? PPFS_FN_OUT : PPFS_FN_IN;
            pu_d[7]   = !port6_bit5_direction && pullup_p6_high;
        end
    end

    // registered pin drive and function report
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_out    <= 8'h00;
            pin_oe     <= 8'h00;
            pin_pullup <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                pin_func[i] <= PPFS_FN_IN;
            end
        end else begin
            pin_out    <= out_d;
            pin_oe     <= oe_d;
            pin_pullup <= pu_d;
            for (int i = 0; i < 8; i++) begin
                pin_func[i] <= func_d[i];
            end
        end
    end

    // oscillator buffer and feedback resistor states
    // the buffer follows the stop bit and the resistor the feedback-disable bit,
    // both only while the sub-clock pins are selected; as ports both are off
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_buffer_on        <= RST_PIN_LOW;
            feedback_resistor_on <= RST_PIN_LOW;
        end else begin
            osc_buffer_on        <= osc_mode && !subclock_stop;
            feedback_resistor_on <= osc_mode && !feedback_resistor_disable;
        end
    end

    // input values delivered to peripherals
    // each peripheral input is forced low while its function is not selected,
    // so a peripheral never sees edges from a pin used for something else
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_level        <= 8'h00;
            ext_irq0_input   <= RST_PIN_LOW;
            serial2_receive  <= RST_PIN_LOW;
            serial2_clock_in <= RST_PIN_LOW;
            subclock_in      <= RST_PIN_LOW;
        end else begin
            pin_level        <= sync2_q;
            ext_irq0_input   <= ext_irq0_enable && !port4_bit5_direction && sync2_q[3];
            serial2_receive  <= !port6_bit4_direction && sync2_q[6];
            serial2_clock_in <= clk_in_on && sync2_q[7];
            subclock_in      <= ext_clk_mode && sync2_q[1];
        end
    end
endmodule : ppfs_mux

// ---- testbench/ppfs_assertions.sv ----
// ppfs_chk: timing and value checks on the pin mux outputs
// assumes: bound to ppfs_mux; outputs follow controls one mclk later
module ppfs_chk (
    input wire logic       mclk, srst,
    input wire logic       timer_a_out_pin_select, timer_a_output_enable, timer_a_output,
    input wire logic       timer_e_pin_select, timer_e_alt_pin_select, timer_e_output_enable, timer_e_output,
    input wire logic       subclock_pin_select, subclock_stop, feedback_resistor_disable,
    input wire logic       serial_mode_bit2, serial_mode_bit1, serial_mode_bit0,
    input wire logic       open_drain_select, serial2_transmit, serial_clock_direction, serial2_clock_out,
    input wire logic [7:0] pin_out, pin_oe,
    input wire logic       osc_buffer_on, feedback_resistor_on
);
    logic [2:0] mode;
    // serial mode field gathered from the loose bits
    assign mode = {serial_mode_bit2, serial_mode_bit1, serial_mode_bit0};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_osc_buf_state:
        assert property (!$past(srst) |-> osc_buffer_on == $past(subclock_pin_select && !subclock_stop))
        else $error("oscillator buffer state wrong");
    a_fb_res_state:
        assert property (!$past(srst) |-> feedback_resistor_on == $past(subclock_pin_select && !feedback_resistor_disable))
        else $error("feedback resistor state wrong");
    a_p37_timer_a:
        assert property (timer_a_out_pin_select && timer_a_output_enable |=> pin_oe[0] && pin_out[0] == $past(timer_a_output))
        else $error("p3.7 timer A drive wrong");
    a_p60_timer_e:
        assert property (!timer_e_pin_select && !timer_e_alt_pin_select && timer_e_output_enable
                         |=> pin_oe[4] && pin_out[4] == $past(timer_e_output))
        else $error("p6.0 timer E drive wrong");
    a_txd_push_pull:
        assert property (mode != 3'h0 && !open_drain_select |=> pin_oe[5] && pin_out[5] == $past(serial2_transmit))
        else $error("p6.3 transmit drive wrong");
    a_txd_open_drain:
        assert property (mode != 3'h0 && open_drain_select |=> !pin_out[5] && pin_oe[5] != $past(serial2_transmit))
        else $error("p6.3 open drain drive wrong");
    a_p65_timer_e:
        assert property (timer_e_alt_pin_select && timer_e_output_enable |=> pin_oe[7] && pin_out[7] == $past(timer_e_output))
        else $error("p6.5 timer E drive wrong");
    a_p65_clk_out:
        assert property (!timer_e_alt_pin_select && !serial_clock_direction && mode == 3'h1
                         |=> pin_oe[7] && pin_out[7] == $past(serial2_clock_out))
        else $error("p6.5 serial clock drive wrong");
    c_txd_od: cover property (mode != 3'h0 && open_drain_select);
    c_clk_out: cover property (!timer_e_alt_pin_select && !serial_clock_direction && mode == 3'h1);
    c_osc_run: cover property (subclock_pin_select && !subclock_stop);
endmodule : ppfs_chk

// ---- testbench/ppfs_pins.sv ----
// ppfs_pins: board side of the multiplexed pins
// assumes: device drive wins over board drive; undriven pins without pull-up wander
module ppfs_pins (
    input  wire logic       mclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_in
);
    logic [7:0] float_q = 8'h55;
    // floating level toggles so no stale value passes for a real one
    always_ff @(posedge mclk) float_q <= ~float_q;
    // resolve each pin from all drivers
    always_comb for (int i = 0; i < 8; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                                                        pin_pullup[i] ? 1'b1 : float_q[i];
endmodule : ppfs_pins

// ---- testbench/port_pin_function_select_tb.sv ----
// port_pin_function_select_tb: random control settings against a rule model
// assumes: ppfs_mux, ppfs_pins and ppfs_chk compiled before this file
module port_pin_function_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0, srst = 1'b1, rx, irq, buf_on, res_on;
    logic [32:0] c = '0;
    logic [6:0]  pod = '0;
    logic [7:0]  xv = '0, pin_in, pin_out, pin_oe, pin_pu;
    logic [31:0] q [$];
    int          num_errors = 0, n_compared = 0;
    wire  [15:0] obs = {pin_pu[1], pin_out[2], irq, rx, pin_pu[6], pin_pu[3], res_on, buf_on, pin_oe[7], pin_out[7],
                        pin_oe[5], pin_out[5], pin_oe[4], pin_out[4], pin_oe[0], pin_out[0]};
    ppfs_mux dut_u (.mclk(mclk), .srst(srst), .port3_bit7_direction(c[0]), .port4_bit3_direction(c[1]),
        .port4_bit4_direction(c[2]), .port4_bit5_direction(c[3]), .port6_bit0_direction(c[4]),
        .port6_bit3_direction(c[5]), .port6_bit4_direction(c[6]), .port6_bit5_direction(c[7]), .port_out_data(pod),
        .timer_a_out_pin_select(c[8]), .timer_a_output_enable(c[9]), .timer_f_out_pin_select(c[10]),
        .timer_f_out4_enable(c[11]), .timer_e_pin_select(c[12]), .timer_e_alt_pin_select(c[13]),
        .timer_e_output_enable(c[14]), .subclock_pin_select(c[15]), .subclock_stop(c[16]),
        .feedback_resistor_disable(c[17]), .ext_irq0_enable(c[18]), .serial_mode_bit2(c[19]),
        .serial_mode_bit1(c[20]), .serial_mode_bit0(c[21]), .serial_clock_direction(c[22]),
        .open_drain_select(c[23]), .pullup_p4_low(c[24]), .pullup_p4_high(c[25]), .pullup_p6_low(c[26]),
        .pullup_p6_high(c[27]), .timer_a_output(c[28]), .timer_f_ch11_output(c[29]), .timer_e_output(c[30]),
        .serial2_transmit(c[31]), .serial2_clock_out(c[32]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pu), .pin_level(), .ext_irq0_input(irq), .serial2_receive(rx), .serial2_clock_in(),
        .subclock_in(), .osc_buffer_on(buf_on), .feedback_resistor_on(res_on), .pin_func());
    ppfs_pins pins_u (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu), .ext_val(xv),
        .ext_en(8'hFF), .pin_in(pin_in));
    // expected outputs and mask of the bits the rules fix
    function automatic logic [31:0] model();
        logic [15:0] e = '0, m = '0;
        logic [2:0]  md = {c[19], c[20], c[21]};
        if (c[8] && c[9]) {e[1:0], m[1:0]} = {1'b1, c[28], 2'h3};
        else if (c[10] && c[11] && !c[9]) {e[1:0], m[1:0]} = {1'b1, c[29], 2'h3};
        else if (!c[9] && !c[11]) {e[1:0], m[1:0]} = {c[0], pod[0], 1'b1, c[0]};
        if (!c[12] && !c[13] && c[14]) {e[3:2], m[3:2]} = {1'b1, c[30], 2'h3};
        else {e[3:2], m[3:2]} = {c[4], pod[4], 1'b1, c[4]};
        if (md == 3'h0) {e[5:4], m[5:4]} = {c[5], pod[5], 1'b1, c[5]};
        else if (c[23]) {e[5:4], m[5:4]} = {~c[31], 1'b0, 2'h3};
        else {e[5:4], m[5:4]} = {1'b1, c[31], 2'h3};
        if (c[13] && c[14]) {e[7:6], m[7:6]} = {1'b1, c[30], 2'h3};
        else if (!c[13] && !c[22] && md == 3'h1) {e[7:6], m[7:6]} = {1'b1, c[32], 2'h3};
        else if (!c[13] && !c[7]) {e[7:6], m[7:6]} = 4'h2;
        else if (!c[13] && md != 3'h1) {e[7:6], m[7:6]} = {1'b1, pod[6], 2'h3};
        {e[9:8], m[9:8]} = {c[15] && !c[17], c[15] && !c[16], 2'h3};
        if (!c[3] && !c[18]) {e[10], m[10]} = {c[25], 1'b1};
        if (!c[6]) {e[12:11], m[12:11]} = {xv[6], c[27], 2'h3};
        if (c[18] && !c[3]) {e[13], m[13]} = {xv[3], 1'b1};
        if (c[15] && !c[16]) {e[14], m[14]} = {~xv[1], 1'b1};
        if (!c[1] && !c[15]) {e[15], m[15]} = {c[24], 1'b1};
        return {m, e};
    endfunction : model
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial forever #5 mclk = ~mclk;
    // driver: random settings, one note per setting
    initial begin
        void'($urandom(5));
        repeat (20) @(posedge mclk);
        #1 srst = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge mclk);
            #1;
            c = 33'({$urandom(), $urandom()});
            pod = 7'($urandom());
            xv = 8'($urandom());
            q.push_back(model());
            repeat (6) @(posedge mclk);
        end
        close_out();
    end
    // monitor: settled outputs against the oldest note
    initial forever begin
        wait (q.size() > 0);
        repeat (5) @(posedge mclk);
        #2;
        n_compared++;
        if ((obs & q[0][31:16]) !== (q[0][15:0] & q[0][31:16])) begin // to
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, obs & q[0][31:16], q[0][15:0] & q[0][31:16]);
        end
        void'(q.pop_front());
    end
    // watchdog against a hang
    initial begin
        #40000;
        num_errors++;
        close_out();
    end
endmodule : port_pin_function_select_tb
bind ppfs_mux ppfs_chk chk_u (.*);
